// *** include/pvn_pkg.sv ***
package pvn_pkg;
    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int          NUM_QUEUES     = 4;        // Queues implemented
    localparam int          QIDX_W         = 16;       // Queue index width
    localparam int          NUM_VECTORS    = 4;        // Message vectors held
    localparam logic [10:0] TABLE_SIZE_FLD = 11'h003;  // Count minus one
    localparam logic [15:0] NO_VECTOR      = 16'hFFFF; // Unmapped marker
    localparam logic [15:0] QDEPTH_MAX     = 16'h0100; // Largest ring depth
    localparam int          PAGE_SHIFT     = 12;       // 4096-byte pages

    // ------------------------------------------------------------------
    // APB register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_QUEUE_ADDR  = 8'h08;
    localparam logic [7:0] OFS_QUEUE_SIZE  = 8'h0C;
    localparam logic [7:0] OFS_QUEUE_SEL   = 8'h2C;  // Own aligned word
    localparam logic [7:0] OFS_QUEUE_NTFY  = 8'h10;
    localparam logic [7:0] OFS_CAUSE       = 8'h14;
    localparam logic [7:0] OFS_CFG_VEC     = 8'h18;
    localparam logic [7:0] OFS_QUEUE_VEC   = 8'h1C;
    localparam logic [7:0] OFS_CTRL        = 8'h20;
    localparam logic [7:0] OFS_TABLE_SIZE  = 8'h24;
    localparam logic [7:0] OFS_LAST_NTFY   = 8'h28;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_MSG_EN   = 0;  // Message interrupts enabled
    localparam int CTRL_NTFY_DAT = 1;  // Notification payload negotiated
    localparam int CAUSE_QUEUE   = 0;  // Used-buffer cause bit
    localparam int CAUSE_CONFIG  = 1;  // Configuration-change cause bit
endpackage

// *** rtl/pvn_notify.sv ***
`timescale 1ns/1ps
// How it works
// (RL1) Four vectors offered, between two and 0x800
// (RL2) Table size field advertises vector count
// (RL3) Any event maps to any valid vector
// (RL4) Selector reads back mapping or unmapped marker
// (RL5) Reset leaves every event unmapped
// (RL6) Out-of-range mapping refused, reads unmapped
// (RL7) Driver copes with any table size
// (RL8) Driver never writes vector beyond table
// (RL9) Driver reads back selector to check
// (RL10) Select queue; absent queue reports depth zero
// (RL11) Ring address held as 4096-byte page number
// (RL12) Plain doorbell carries 16-bit queue index
// (RL13) Payload doorbell: queue, offset, wrap fields
// (RL14) Pin mode queue event sets cause bit0
// (RL15) Message mode queue event sends mapped vector
// (RL16) Unmapped queue in message mode: no interrupt
// (RL17) Pin mode config change sets cause bit1
// (RL18) Message mode config change uses config vector
// (RL19) One interrupt may report both events
// (RL20) Reading cause returns bits and clears
// (RL21) Driver scans queues on message vector
// (RL22) Unmapped marker is 0xFFFF
// (RL23) Cause unused while message mode enabled
// (RL24) Pin interrupt follows any set cause bit
module pvn_notify
    import pvn_pkg::*;
(
    // Clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Device-side events, one-cycle pulses on REF_CLK
    input  wire logic [NUM_QUEUES-1:0] USED_EVT,
    input  wire logic        CFG_EVT,
    // Interrupt outputs
    output logic             INT_PIN,
    output logic             MSG_REQ,
    output logic      [15:0] MSG_VEC,
    // Doorbell outputs
    output logic             NTFY_VALID,
    output logic      [15:0] NTFY_QUEUE,
    output logic      [14:0] NTFY_OFF,
    output logic             NTFY_WRAP
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [15:0] qsel_q, qsel_d;                       // Selected queue
    logic [15:0] qsize_q [NUM_QUEUES], qsize_d [NUM_QUEUES];  // Depths
    logic [31:0] qaddr_q [NUM_QUEUES], qaddr_d [NUM_QUEUES];  // Page numbers
    logic [15:0] qvec_q  [NUM_QUEUES], qvec_d  [NUM_QUEUES];  // Queue vectors
    logic [15:0] cvec_q, cvec_d;                       // Config vector
    logic [1:0]  ctrl_q, ctrl_d;                       // Mode bits
    logic [1:0]  cause_q, cause_d;                     // Interrupt cause
    logic [31:0] prdata_q, prdata_d;                   // Read data
    logic        pslverr_q, pslverr_d;
    logic        int_q, int_d;                         // Pin interrupt
    logic        mreq_q, mreq_d;                       // Message strobe
    logic [15:0] mvec_q, mvec_d;
    logic        nv_q, nv_d;                           // Doorbell strobe
    logic [31:0] nword_q, nword_d;                     // Last doorbell word
    logic [NUM_QUEUES-1:0] pend_q, pend_d;             // Queued messages
    logic        cpend_q, cpend_d;

    logic        wr_acc, rd_acc;                       // Commit and capture strobes
    logic        acc_first;                            // First access-phase edge
    logic        addr_ok;                              // Address decodes to a register
    logic        rdy_q;                                // Wait state served
    logic        q_ok;                                 // Selected queue exists
    logic [1:0]  qi;                                   // Selected queue slot
    logic        msg_en;

    // Writes commit only on the completing edge, so each acts exactly once
    assign acc_first = PSEL && PENABLE && !rdy_q;
    assign wr_acc    = PSEL && PENABLE && PWRITE && rdy_q;
    assign rd_acc    = acc_first && !PWRITE;
    assign addr_ok   = PADDR inside {OFS_QUEUE_ADDR, OFS_QUEUE_SIZE, OFS_QUEUE_SEL,
                                     OFS_QUEUE_NTFY, OFS_CAUSE, OFS_CFG_VEC, OFS_QUEUE_VEC,
                                     OFS_CTRL, OFS_TABLE_SIZE, OFS_LAST_NTFY};
    assign q_ok   = qsel_q < 16'(NUM_QUEUES);  // RL10
    assign qi     = qsel_q[1:0];
    assign msg_en = ctrl_q[CTRL_MSG_EN];

    // Vector request accepted only inside the table, else unmapped
    function automatic logic [15:0] map_vec(input logic [15:0] v);
        if (v <= 16'(TABLE_SIZE_FLD)) begin
            map_vec = v;  // RL3
        end else begin
            map_vec = NO_VECTOR;  // RL6 RL22
        end
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        int sel;
        sel = 0;
        qsel_d    = qsel_q;
        qsize_d   = qsize_q;
        qaddr_d   = qaddr_q;
        qvec_d    = qvec_q;
        cvec_d    = cvec_q;
        ctrl_d    = ctrl_q;
        cause_d   = cause_q;
        prdata_d  = prdata_q;
        pslverr_d = acc_first && !addr_ok;
        nv_d      = 1'b0;
        nword_d   = nword_q;
        mreq_d    = 1'b0;
        mvec_d    = mvec_q;
        pend_d    = pend_q;
        cpend_d   = cpend_q;

        // Events: message mode queues a vector, pin mode sets cause
        if (msg_en) begin
            for (int i = 0; i < NUM_QUEUES; i++) begin
                if (USED_EVT[i] && qvec_q[i] != NO_VECTOR) begin
                    pend_d[i] = 1'b1;  // RL15
                end
            end
            if (CFG_EVT && cvec_q != NO_VECTOR) begin
                cpend_d = 1'b1;  // RL18
            end
        end

        // Register access; read clears cause before events are merged
        if (wr_acc) begin
            case (PADDR)
                OFS_QUEUE_ADDR: if (q_ok) qaddr_d[qi] = PWDATA;  // RL11
                OFS_QUEUE_SIZE: begin
                    // Only a nonzero depth no larger than the maximum is taken
                    if (q_ok && PWDATA[15:0] != 16'h0000 && PWDATA[15:0] <= QDEPTH_MAX) begin
                        qsize_d[qi] = PWDATA[15:0];  // RL10
                    end
                end
                OFS_QUEUE_SEL:  qsel_d = PWDATA[15:0];
                OFS_QUEUE_NTFY: begin
                    nv_d = 1'b1;
                    if (ctrl_q[CTRL_NTFY_DAT]) begin
                        nword_d = PWDATA;  // RL13
                    end else begin
                        nword_d = {16'h0000, PWDATA[15:0]};  // RL12
                    end
                end
                OFS_CFG_VEC:    cvec_d = map_vec(PWDATA[15:0]);  // RL3 RL6
                OFS_QUEUE_VEC:  if (q_ok) qvec_d[qi] = map_vec(PWDATA[15:0]);  // RL3 RL6
                OFS_CTRL:       ctrl_d = PWDATA[1:0];
                default:        ;  // Read-only or unknown: write ignored
            endcase
        end else if (rd_acc) begin
            case (PADDR)
                OFS_QUEUE_ADDR: prdata_d = q_ok ? qaddr_q[qi] : 32'h0000_0000;
                OFS_QUEUE_SIZE: prdata_d = {16'h0000, q_ok ? qsize_q[qi] : 16'h0000};  // RL10
                OFS_QUEUE_SEL:  prdata_d = {16'h0000, qsel_q};
                OFS_QUEUE_NTFY: prdata_d = 32'h0000_0000;
                OFS_CAUSE: begin
                    prdata_d = {30'h0, cause_q};
                    cause_d  = 2'b00;  // RL20
                end
                OFS_CFG_VEC:    prdata_d = {16'h0000, cvec_q};  // RL4
                OFS_QUEUE_VEC:  prdata_d = {16'h0000, q_ok ? qvec_q[qi] : NO_VECTOR};  // RL4
                OFS_CTRL:       prdata_d = {30'h0, ctrl_q};
                OFS_TABLE_SIZE: prdata_d = {21'h0, TABLE_SIZE_FLD};  // RL1 RL2
                OFS_LAST_NTFY:  prdata_d = nword_q;
                default: begin
                    prdata_d  = 32'h0000_0000;
                    pslverr_d = 1'b1;
                end
            endcase
        end

        // Pin mode causes: set wins over the read clear
        if (!msg_en) begin
            if (|USED_EVT) cause_d[CAUSE_QUEUE] = 1'b1;  // RL14
            if (CFG_EVT)   cause_d[CAUSE_CONFIG] = 1'b1;  // RL17
        end else begin
            cause_d = (rd_acc && PADDR == OFS_CAUSE) ? 2'b00 : cause_q;  // RL23
        end

        // One message per cycle, config first, then lowest queue
        if (cpend_q) begin
            mreq_d  = 1'b1;
            mvec_d  = cvec_q;  // RL18
            cpend_d = 1'b0;
        end else begin
            for (int i = NUM_QUEUES - 1; i >= 0; i--) begin
                if (pend_q[i]) sel = i;
            end
            if (|pend_q) begin
                mreq_d      = 1'b1;
                mvec_d      = qvec_q[sel];  // RL15
                pend_d[sel] = 1'b0;
            end
        end
        // A remapping to unmapped or leaving message mode drops queued messages
        for (int i = 0; i < NUM_QUEUES; i++) begin
            if (qvec_d[i] == NO_VECTOR || !ctrl_d[CTRL_MSG_EN]) pend_d[i] = 1'b0;  // RL16
        end
        if (cvec_d == NO_VECTOR || !ctrl_d[CTRL_MSG_EN]) cpend_d = 1'b0;  // RL18

        int_d = |cause_d && !ctrl_d[CTRL_MSG_EN];  // RL24 RL19
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            qsel_q    <= 16'h0000;
            for (int i = 0; i < NUM_QUEUES; i++) begin
                qsize_q[i] <= QDEPTH_MAX;
                qaddr_q[i] <= 32'h0000_0000;
                qvec_q[i]  <= NO_VECTOR;  // RL5
            end
            cvec_q    <= NO_VECTOR;  // RL5
            ctrl_q    <= 2'b00;
            cause_q   <= 2'b00;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
            int_q     <= 1'b0;
            mreq_q    <= 1'b0;
            mvec_q    <= 16'h0000;
            nv_q      <= 1'b0;
            nword_q   <= 32'h0000_0000;
            pend_q    <= '0;
            cpend_q   <= 1'b0;
        end else begin
            qsel_q    <= qsel_d;
            qsize_q   <= qsize_d;
            qaddr_q   <= qaddr_d;
            qvec_q    <= qvec_d;
            cvec_q    <= cvec_d;
            ctrl_q    <= ctrl_d;
            cause_q   <= cause_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
            int_q     <= int_d;
            mreq_q    <= mreq_d;
            mvec_q    <= mvec_d;
            nv_q      <= nv_d;
            nword_q   <= nword_d;
            pend_q    <= pend_d;
            cpend_q   <= cpend_d;
        end
    end

    // One wait state: read data and error are registered at the first
    // access edge and shown while PREADY stands for one cycle
    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdy_q <= 1'b0;
        end else begin
            rdy_q <= PSEL && PENABLE && !rdy_q;
        end
    end

    assign PREADY     = rdy_q;
    assign PRDATA     = prdata_q;
    assign PSLVERR    = pslverr_q;
    assign INT_PIN    = int_q;
    assign MSG_REQ    = mreq_q;
    assign MSG_VEC    = mvec_q;
    assign NTFY_VALID = nv_q;
    assign NTFY_QUEUE = nword_q[15:0];
    assign NTFY_OFF   = nword_q[30:16];
    assign NTFY_WRAP  = nword_q[31];

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    property p_reset_unmapped;
        @(posedge REF_CLK) $rose(RST_N) |-> cvec_q == NO_VECTOR;
    endproperty
    a_reset_unmapped: assert property (p_reset_unmapped) else $error("cfg vector mapped after reset"); // RL5

    property p_refuse;
        @(posedge REF_CLK) disable iff (!RST_N)
        rd_acc && PADDR == OFS_QUEUE_VEC && !q_ok |=> PRDATA == {16'h0000, NO_VECTOR};
    endproperty
    a_refuse: assert property (p_refuse) else $error("absent queue mapping kept"); // RL6

    property p_map_ok;
        @(posedge REF_CLK) disable iff (!RST_N)
        wr_acc && PADDR == OFS_CFG_VEC && PWDATA[15:0] <= 16'(TABLE_SIZE_FLD)
        |=> cvec_q == $past(PWDATA[15:0]);
    endproperty
    a_map_ok: assert property (p_map_ok) else $error("valid vector not stored"); // RL3

    property p_pin_queue;
        @(posedge REF_CLK) disable iff (!RST_N)
        !msg_en && USED_EVT != '0 |=> cause_q[CAUSE_QUEUE] ##1 INT_PIN;
    endproperty
    a_pin_queue: assert property (p_pin_queue) else $error("queue cause not raised"); // RL14

    property p_pin_cfg;
        @(posedge REF_CLK) disable iff (!RST_N)
        !msg_en && CFG_EVT |=> cause_q[CAUSE_CONFIG];
    endproperty
    a_pin_cfg: assert property (p_pin_cfg) else $error("config cause not raised"); // RL17

    property p_msg_cfg;
        @(posedge REF_CLK) disable iff (!RST_N)
        msg_en && CFG_EVT && cvec_q != NO_VECTOR && !wr_acc |-> ##[1:2] MSG_REQ && MSG_VEC == cvec_q;
    endproperty
    a_msg_cfg: assert property (p_msg_cfg) else $error("config message missing"); // RL18

    property p_no_unmapped;
        @(posedge REF_CLK) disable iff (!RST_N)
        MSG_REQ |-> MSG_VEC != NO_VECTOR;
    endproperty
    a_no_unmapped: assert property (p_no_unmapped) else $error("message sent unmapped"); // RL16

    property p_msg_quiet_cause;
        @(posedge REF_CLK) disable iff (!RST_N)
        msg_en && cause_q == 2'b00 |=> cause_q == 2'b00;
    endproperty
    a_msg_quiet_cause: assert property (p_msg_quiet_cause) else $error("cause used in msg mode"); // RL23

    property p_pin_follows;
        @(posedge REF_CLK) disable iff (!RST_N)
        !msg_en && !ctrl_d[CTRL_MSG_EN] |=> INT_PIN == (cause_q != 2'b00);
    endproperty
    a_pin_follows: assert property (p_pin_follows) else $error("pin disagrees with cause"); // RL24
endmodule

// *** tb/pvn_host_drv.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Host driver model, APB master side
// ----------------------------------------
module pvn_host_drv
    import pvn_pkg::*;
(
    // Clock
    input  wire logic        ref_clk,
    // APB master
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    // Raised when a slave never answers
    output logic             tmo
);
    // Idle bus at time zero
    initial begin
        {psel, penable, pwrite, paddr, pwdata, tmo} = '0;
    end

    // One transfer; the idle edge first lets last PREADY drop
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        int i;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // Ready and data are taken as sampled at the completing edge
        for (i = 0; i < 16; i++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        // Bounded wait, never hang
        if (i == 16) tmo <= 1'b1;
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Map then read back; out-of-table numbers become unmap
    task automatic map_vec(input logic [7:0] ofs, input logic [15:0] v,
                           output logic [15:0] back);
        logic [31:0] rd;
        logic        err;
        if (v > {5'h00, TABLE_SIZE_FLD} && v !== NO_VECTOR) v = NO_VECTOR;
        xfer(1'b1, ofs, {16'h0000, v}, rd, err);
        xfer(1'b0, ofs, 32'h0000_0000, rd, err);
        back = rd[15:0];
    endtask

    // Doorbell in either format
    task automatic ring(input logic pay, input logic [15:0] q, input logic [14:0] off,
                        input logic wrap);
        logic [31:0] rd;
        logic        err;
        if (pay) xfer(1'b1, OFS_QUEUE_NTFY, {wrap, off, q}, rd, err);
        else xfer(1'b1, OFS_QUEUE_NTFY, {16'h0000, q}, rd, err);
    endtask
endmodule

// *** tb/test_pci_vector_map_notify.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module test_pci_vector_map_notify
    import pvn_pkg::*;
;
    logic                  ref_clk = 1'b0;
    logic                  rst_n   = 1'b0;
    logic                  psel, penable, pwrite, pready, pslverr, tmo;
    logic [7:0]            paddr;
    logic [31:0]           pwdata, prdata, rd;
    logic [NUM_QUEUES-1:0] used_evt = '0;
    logic                  cfg_evt  = 1'b0;
    logic                  int_pin, msg_req, ntfy_valid, ntfy_wrap, err;
    logic [15:0]           msg_vec, ntfy_queue, back;
    logic [14:0]           ntfy_off;
    int                    num_errors = 0;
    int                    n_checks   = 0;
    int                    ntfy_cnt   = 0;

    // 25 MHz clock
    always #20 ref_clk = ~ref_clk;

    pvn_notify pvn_notify_i (.REF_CLK(ref_clk), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .USED_EVT(used_evt),
        .CFG_EVT(cfg_evt), .INT_PIN(int_pin), .MSG_REQ(msg_req), .MSG_VEC(msg_vec),
        .NTFY_VALID(ntfy_valid), .NTFY_QUEUE(ntfy_queue), .NTFY_OFF(ntfy_off),
        .NTFY_WRAP(ntfy_wrap));
    pvn_host_drv pvn_host_drv_i (.ref_clk(ref_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tmo(tmo));

    // Doorbell strobes seen
    always @(posedge ref_clk) if (ntfy_valid === 1'b1) ntfy_cnt++;

    // Verdict and end of run
    task automatic wrap_up();
        $display("errors %0d checks %0d", num_errors, n_checks);
        if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // A hung bus ends the run
    always @(posedge tmo) begin
        num_errors++;
        wrap_up();
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", nm, exp, got);
            num_errors++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        pvn_host_drv_i.xfer(1'b1, a, d, rd, err);
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        pvn_host_drv_i.xfer(1'b0, a, 32'h0000_0000, rd, err);
        chk(nm, exp, rd);
    endtask
    // One-cycle event pulse; returns on the edge that samples it
    task automatic pulse(input logic [NUM_QUEUES-1:0] q, input logic c);
        @(posedge ref_clk);
        used_evt <= q;
        cfg_evt  <= c;
        @(posedge ref_clk);
        used_evt <= '0;
        cfg_evt  <= 1'b0;
    endtask
    // Count message strobes over ten cycles, check the first vector
    task automatic msgs(input int n, input logic [15:0] v);
        int hits;
        hits = 0;
        repeat (10) begin
            #1;
            if (msg_req === 1'b1) begin
                if (hits == 0) chk("msg_vec", {16'h0000, v}, {16'h0000, msg_vec});
                hits++;
            end
            @(posedge ref_clk);
        end
        chk("msg_count", n, hits);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        rdc("cfg_vec", OFS_CFG_VEC, 32'h0000_FFFF);
        rdc("q_vec", OFS_QUEUE_VEC, 32'h0000_FFFF);
        rdc("tsize", OFS_TABLE_SIZE, {21'h0, TABLE_SIZE_FLD});
        rdc("ctrl", OFS_CTRL, 32'h0000_0000);
        pvn_host_drv_i.xfer(1'b0, 8'h3C, 32'h0, rd, err);
        chk("unmapped_err", 32'h1, {31'h0, err});
        chk("unmapped_data", 32'h0, rd);
        // Lowest vector boundary
        pvn_host_drv_i.map_vec(OFS_CFG_VEC, 16'h0000, back);
        chk("map0", 32'h0, {16'h0, back});
        // Queue geometry
        for (int q = 0; q < NUM_QUEUES; q++) begin
            wr(OFS_QUEUE_SEL, q);
            rdc("qdepth", OFS_QUEUE_SIZE, {16'h0, QDEPTH_MAX});
        end
        wr(OFS_QUEUE_SEL, NUM_QUEUES);
        rdc("absent_depth", OFS_QUEUE_SIZE, 32'h0);
        rdc("absent_vec", OFS_QUEUE_VEC, 32'h0000_FFFF);
        pvn_host_drv_i.map_vec(OFS_QUEUE_VEC, 16'h0002, back);
        chk("map_refused", 32'h0000_FFFF, {16'h0, back});
        wr(OFS_QUEUE_SEL, 32'h1);
        wr(OFS_QUEUE_SIZE, 32'h40);
        rdc("small_depth", OFS_QUEUE_SIZE, 32'h40);
        wr(OFS_QUEUE_ADDR, 32'h000A_BCDE);
        rdc("page", OFS_QUEUE_ADDR, 32'h000A_BCDE);
        // Pin mode events
        pulse(4'b0010, 1'b0);
        repeat (2) @(posedge ref_clk);
        #1 chk("int_pin", 32'h1, {31'h0, int_pin});
        rdc("cause_q", OFS_CAUSE, 32'h1);
        rdc("cause_clr", OFS_CAUSE, 32'h0);
        repeat (2) @(posedge ref_clk);
        #1 chk("int_off", 32'h0, {31'h0, int_pin});
        pulse(4'b0000, 1'b1);
        rdc("cause_cfg", OFS_CAUSE, 32'h2);
        pulse(4'b0001, 1'b1);
        rdc("cause_both", OFS_CAUSE, 32'h3);
        // Message mode
        wr(OFS_CTRL, 32'h1);
        pvn_host_drv_i.map_vec(OFS_CFG_VEC, 16'h0003, back);
        chk("map3", 32'h3, {16'h0, back});
        wr(OFS_QUEUE_SEL, 32'h0);
        pvn_host_drv_i.map_vec(OFS_QUEUE_VEC, 16'h0001, back);
        chk("qmap1", 32'h1, {16'h0, back});
        pulse(4'b0000, 1'b1);
        msgs(1, 16'h0003);
        pulse(4'b0001, 1'b0);
        msgs(1, 16'h0001);
        rdc("scan_q0", OFS_QUEUE_VEC, 32'h0000_0001);
        pulse(4'b0001, 1'b1);
        msgs(2, 16'h0003);
        pulse(4'b0100, 1'b0);
        msgs(0, 16'h0000);
        chk("int_msg_mode", 32'h0, {31'h0, int_pin});
        rdc("cause_unused", OFS_CAUSE, 32'h0);
        pvn_host_drv_i.map_vec(OFS_CFG_VEC, NO_VECTOR, back);
        chk("unmap", 32'h0000_FFFF, {16'h0, back});
        pulse(4'b0000, 1'b1);
        msgs(0, 16'h0000);
        // Doorbells, plain then payload
        wr(OFS_CTRL, 32'h0);
        pvn_host_drv_i.ring(1'b0, 16'h0002, 15'h0005, 1'b1);
        #1 chk("plain_db", 32'h2, {ntfy_wrap, ntfy_off, ntfy_queue});
        wr(OFS_CTRL, 32'h2);
        ntfy_cnt = 0;
        pvn_host_drv_i.ring(1'b1, 16'h0001, 15'h1234, 1'b1);
        #1 chk("pay_db", 32'h9234_0001, {ntfy_wrap, ntfy_off, ntfy_queue});
        rdc("last_db", OFS_LAST_NTFY, 32'h9234_0001);
        chk("db_strobe", 32'h1, ntfy_cnt);
        wrap_up();
    end
endmodule
